// ===== logic/mcc_pkg.sv
// Constants and types shared by the instruction execute unit
package mcc_pkg;
  // Register offsets on the APB slave (byte addresses)
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] WREG_OFS = 8'h04;
  localparam logic [7:0] STAT_OFS = 8'h08;
  localparam logic [7:0] PC_OFS = 8'h0c;
  // Field positions
  localparam int CTRL_RUN_BIT = 0;
  localparam int STAT_Z_BIT = 0;
  localparam int STAT_TO_BIT = 1;
  localparam int STAT_PD_BIT = 2;
  // Values after reset
  localparam logic RUN_RST = 1'b0;
  localparam logic [7:0] W_RST = 8'h00;
  localparam logic Z_RST = 1'b0;
  localparam logic TO_RST = 1'b1;
  localparam logic PD_RST = 1'b1;
  localparam logic [12:0] PC_RST = 13'h0000;
  // Flag values left behind by a watchdog clear
  localparam logic TO_AFTER_CLR = 1'b1;
  localparam logic PD_AFTER_CLR = 1'b1;
  // Opcode fields
  localparam logic [15:0] OPC_CLEAR_ACCUM = 16'h0140;
  localparam logic [15:0] OPC_WATCHDOG_CLR = 16'h1e04;
  localparam logic [1:0] FILE_GROUP = 2'h0;
  localparam logic [3:0] SUB_CLEAR_FILE = 4'h1;
  localparam logic [3:0] SUB_COMPLEMENT = 4'h9;
  localparam logic [3:0] SUB_DECREMENT = 4'h3;
  localparam logic [3:0] SUB_DEC_SKIP = 4'hb;
  localparam logic [3:0] SUB_INCREMENT = 4'ha;
  localparam logic [3:0] SUB_INC_SKIP = 4'hf;
  localparam logic [3:0] SUB_OR_FILE = 4'h4;
  localparam logic [7:0] LIT_OR_ACCUM = 8'h1a;
  localparam logic [2:0] CALL_GROUP = 3'h4;
  localparam logic [7:0] ONE_8 = 8'h01;
  localparam logic [12:0] ONE_13 = 13'h0001;

  typedef enum logic [3:0] {
    OP_NONE = 4'h0,
    OP_CLEAR_FILE = 4'h1,
    OP_CLEAR_ACCUM = 4'h2,
    OP_WATCHDOG_CLR = 4'h3,
    OP_COMPLEMENT = 4'h4,
    OP_DECREMENT = 4'h5,
    OP_DEC_SKIP = 4'h6,
    OP_INCREMENT = 4'h7,
    OP_INC_SKIP = 4'h8,
    OP_OR_LITERAL = 4'h9,
    OP_OR_FILE = 4'ha,
    OP_CALL = 4'hb
  } mcc_op_t;

  typedef enum logic [2:0] {
    ST_EXEC = 3'b001,
    ST_SKIP = 3'b010,
    ST_CALL = 3'b100
  } mcc_state_t;
endpackage

// ===== logic/mcc_decode.sv
// Opcode decoder: instruction class and operand fields
`timescale 1ns/1ns
module mcc_decode (
  input wire logic [15:0] opcode,
  output mcc_pkg::mcc_op_t op,
  output logic [8:0] faddr,
  output logic dest,
  output logic [7:0] lit,
  output logic [12:0] target
);
  function automatic mcc_pkg::mcc_op_t classify(input logic [15:0] c);
    mcc_pkg::mcc_op_t r;
    r = mcc_pkg::OP_NONE;
    if (c == mcc_pkg::OPC_CLEAR_ACCUM) begin
      r = mcc_pkg::OP_CLEAR_ACCUM;
    end else if (c == mcc_pkg::OPC_WATCHDOG_CLR) begin
      r = mcc_pkg::OP_WATCHDOG_CLR;
    end else if (c[15:8] == mcc_pkg::LIT_OR_ACCUM) begin
      r = mcc_pkg::OP_OR_LITERAL;
    end else if (c[13:11] == mcc_pkg::CALL_GROUP) begin
      r = mcc_pkg::OP_CALL;
    end else if (c[13:12] == mcc_pkg::FILE_GROUP) begin
      case (c[11:8])
        mcc_pkg::SUB_CLEAR_FILE: r = c[7] ? mcc_pkg::OP_CLEAR_FILE : mcc_pkg::OP_NONE;
        mcc_pkg::SUB_COMPLEMENT: r = mcc_pkg::OP_COMPLEMENT;
        mcc_pkg::SUB_DECREMENT: r = mcc_pkg::OP_DECREMENT;
        mcc_pkg::SUB_DEC_SKIP: r = mcc_pkg::OP_DEC_SKIP;
        mcc_pkg::SUB_INCREMENT: r = mcc_pkg::OP_INCREMENT;
        mcc_pkg::SUB_INC_SKIP: r = mcc_pkg::OP_INC_SKIP;
        mcc_pkg::SUB_OR_FILE: r = mcc_pkg::OP_OR_FILE;
        default: r = mcc_pkg::OP_NONE;
      endcase
    end
    return r;
  endfunction

  assign op = classify(opcode);
  assign faddr = {opcode[15:14], opcode[6:0]};
  assign dest = opcode[7];
  assign lit = opcode[7:0];
  assign target = {opcode[15:14], opcode[10:0]};
endmodule

// ===== logic/mcc_alu.sv
// Byte datapath for clear, complement, step and OR
`timescale 1ns/1ns
module mcc_alu (
  input mcc_pkg::mcc_op_t op,
  input wire logic [7:0] fval,
  input wire logic [7:0] wval,
  input wire logic [7:0] lit,
  output logic [7:0] result,
  output logic zero
);
  always_comb begin
    case (op)
      mcc_pkg::OP_COMPLEMENT: result = ~fval;
      mcc_pkg::OP_DECREMENT,
      mcc_pkg::OP_DEC_SKIP: result = fval - mcc_pkg::ONE_8;
      mcc_pkg::OP_INCREMENT,
      mcc_pkg::OP_INC_SKIP: result = fval + mcc_pkg::ONE_8;
      mcc_pkg::OP_OR_LITERAL: result = wval | lit;
      mcc_pkg::OP_OR_FILE: result = wval | fval;
      default: result = 8'h00;
    endcase
  end

  assign zero = (result == 8'h00);
endmodule

// ===== logic/mcc_core_exec.sv
// Execute unit of an 8-bit core: clears, steps, OR and subroutine call
`timescale 1ns/1ns
module mcc_core_exec (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [12:0] instr_addr,
  input wire logic [15:0] instr_data,
  output logic [8:0] file_addr,
  input wire logic [7:0] file_rd_data,
  output logic file_wr_en,
  output logic [8:0] file_wr_addr,
  output logic [7:0] file_wr_data,
  output logic stack_push,
  output logic [12:0] stack_push_data,
  output logic wdt_clear
);
  mcc_pkg::mcc_op_t op;
  mcc_pkg::mcc_state_t state;
  logic [8:0] faddr;
  logic dest;
  logic [7:0] lit;
  logic [12:0] target;
  logic [7:0] fval;
  logic [7:0] alu_result;
  logic alu_zero;
  logic run;
  logic [7:0] w;
  logic z;
  logic timeout_flag;
  logic powerdown_flag;
  logic [12:0] pc;
  logic [12:0] pc_inc;
  logic exec;
  logic routed_op;
  logic write_w;
  logic write_f;
  logic upd_z;
  logic skip;
  logic apb_wr;
  logic apb_setup;

  function automatic logic reg_mapped(input logic [7:0] a);
    logic hit;
    hit = 1'b0;
    if (a == mcc_pkg::CTRL_OFS) begin
      hit = 1'b1;
    end else if (a == mcc_pkg::WREG_OFS) begin
      hit = 1'b1;
    end else if (a == mcc_pkg::STAT_OFS) begin
      hit = 1'b1;
    end else if (a == mcc_pkg::PC_OFS) begin
      hit = 1'b1;
    end
    return hit;
  endfunction

  mcc_decode u_decode (
    .opcode(instr_data),
    .op(op),
    .faddr(faddr),
    .dest(dest),
    .lit(lit),
    .target(target)
  );

  // Bypass a file write still in flight to the same address
  assign fval = (file_wr_en && file_wr_addr == faddr) ? file_wr_data : file_rd_data;

  mcc_alu u_alu (
    .op(op),
    .fval(fval),
    .wval(w),
    .lit(lit),
    .result(alu_result),
    .zero(alu_zero)
  );

  assign instr_addr = pc;
  assign file_addr = faddr;
  assign pc_inc = pc + mcc_pkg::ONE_13;
  assign exec = run && (state == mcc_pkg::ST_EXEC);
  assign routed_op = (op == mcc_pkg::OP_COMPLEMENT) || (op == mcc_pkg::OP_DECREMENT) ||
                     (op == mcc_pkg::OP_DEC_SKIP) || (op == mcc_pkg::OP_INCREMENT) ||
                     (op == mcc_pkg::OP_INC_SKIP) || (op == mcc_pkg::OP_OR_FILE);
  assign write_w = (routed_op && !dest) || (op == mcc_pkg::OP_CLEAR_ACCUM) ||
                   (op == mcc_pkg::OP_OR_LITERAL);
  assign write_f = (routed_op && dest) || (op == mcc_pkg::OP_CLEAR_FILE);
  assign upd_z = (op == mcc_pkg::OP_CLEAR_FILE) || (op == mcc_pkg::OP_CLEAR_ACCUM) ||
                 (op == mcc_pkg::OP_COMPLEMENT) || (op == mcc_pkg::OP_DECREMENT) ||
                 (op == mcc_pkg::OP_INCREMENT) || (op == mcc_pkg::OP_OR_LITERAL) ||
                 (op == mcc_pkg::OP_OR_FILE);
  assign skip = ((op == mcc_pkg::OP_DEC_SKIP) || (op == mcc_pkg::OP_INC_SKIP)) && alu_zero;

  // APB slave, zero wait states
  assign apb_wr = psel && penable && pwrite;
  assign apb_setup = psel && !penable;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !reg_mapped(paddr);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
    end else if (apb_setup && !pwrite) begin
      prdata <= 32'h0000_0000;
      if (paddr == mcc_pkg::CTRL_OFS) begin
        prdata[mcc_pkg::CTRL_RUN_BIT] <= run;
      end else if (paddr == mcc_pkg::WREG_OFS) begin
        prdata[7:0] <= w;
      end else if (paddr == mcc_pkg::STAT_OFS) begin
        prdata[mcc_pkg::STAT_Z_BIT] <= z;
        prdata[mcc_pkg::STAT_TO_BIT] <= timeout_flag;
        prdata[mcc_pkg::STAT_PD_BIT] <= powerdown_flag;
      end else if (paddr == mcc_pkg::PC_OFS) begin
        prdata[12:0] <= pc;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      run <= mcc_pkg::RUN_RST;
    end else if (apb_wr && paddr == mcc_pkg::CTRL_OFS) begin
      run <= pwdata[mcc_pkg::CTRL_RUN_BIT];
    end
  end

  // Working register; the core wins over a software write
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      w <= mcc_pkg::W_RST;
    end else if (exec && write_w) begin
      w <= alu_result;
    end else if (apb_wr && paddr == mcc_pkg::WREG_OFS) begin
      w <= pwdata[7:0];
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      z <= mcc_pkg::Z_RST;
    end else if (exec && upd_z) begin
      z <= alu_zero;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      timeout_flag <= mcc_pkg::TO_RST;
      powerdown_flag <= mcc_pkg::PD_RST;
      wdt_clear <= 1'b0;
    end else begin
      wdt_clear <= exec && (op == mcc_pkg::OP_WATCHDOG_CLR);
      if (exec && op == mcc_pkg::OP_WATCHDOG_CLR) begin
        timeout_flag <= mcc_pkg::TO_AFTER_CLR;
        powerdown_flag <= mcc_pkg::PD_AFTER_CLR;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      file_wr_en <= 1'b0;
      file_wr_addr <= 9'h000;
      file_wr_data <= 8'h00;
    end else begin
      file_wr_en <= exec && write_f;
      if (exec && write_f) begin
        file_wr_addr <= faddr;
        file_wr_data <= alu_result;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      stack_push <= 1'b0;
      stack_push_data <= 13'h0000;
    end else begin
      stack_push <= exec && (op == mcc_pkg::OP_CALL);
      if (exec && op == mcc_pkg::OP_CALL) begin
        stack_push_data <= pc_inc;
      end
    end
  end

  // Sequencer: skip slot and second call cycle
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state <= mcc_pkg::ST_EXEC;
      pc <= mcc_pkg::PC_RST;
    end else if (!run) begin
      if (apb_wr && paddr == mcc_pkg::PC_OFS) begin
        pc <= pwdata[12:0];
      end
    end else begin
      case (state)
        mcc_pkg::ST_EXEC: begin
          if (op == mcc_pkg::OP_CALL) begin
            pc <= target;
            state <= mcc_pkg::ST_CALL;
          end else begin
            pc <= pc_inc;
            if (skip) begin
              state <= mcc_pkg::ST_SKIP;
            end
          end
        end
        mcc_pkg::ST_SKIP: begin
          pc <= pc_inc;
          state <= mcc_pkg::ST_EXEC;
        end
        mcc_pkg::ST_CALL: begin
          state <= mcc_pkg::ST_EXEC;
        end
        default: begin
          state <= mcc_pkg::ST_EXEC;
        end
      endcase
    end
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  sequence skip_slot_s;
    (state == mcc_pkg::ST_SKIP) ##1 (state == mcc_pkg::ST_EXEC);
  endsequence

  sequence call_tail_s;
    stack_push && (state == mcc_pkg::ST_CALL) ##1 !stack_push && (state == mcc_pkg::ST_EXEC);
  endsequence

  clear_file_a: assert property (exec && op == mcc_pkg::OP_CLEAR_FILE |=>
    file_wr_en && file_wr_data == 8'h00 && file_wr_addr == $past(faddr) && z)
    else $error("clear file did not zero register and set zero flag");

  clear_accum_a: assert property (exec && op == mcc_pkg::OP_CLEAR_ACCUM |=>
    w == 8'h00 && z && !file_wr_en)
    else $error("clear accumulator did not zero working register");

  wdt_pulse_a: assert property (exec && op == mcc_pkg::OP_WATCHDOG_CLR |=>
    wdt_clear && state == mcc_pkg::ST_EXEC)
    else $error("watchdog clear pulse missing");

  wdt_flags_a: assert property (exec && op == mcc_pkg::OP_WATCHDOG_CLR |=>
    timeout_flag == mcc_pkg::TO_AFTER_CLR && powerdown_flag == mcc_pkg::PD_AFTER_CLR)
    else $error("watchdog clear left timeout or powerdown flag wrong");

  dest_route_a: assert property (exec && routed_op && !dest |=>
    !file_wr_en && w == $past(alu_result))
    else $error("destination zero did not route to working register");

  file_addr_a: assert property (exec && routed_op |->
    file_addr == {instr_data[15:14], instr_data[6:0]})
    else $error("file address decoded wrongly");

  complement_a: assert property (exec && op == mcc_pkg::OP_COMPLEMENT && dest |=>
    file_wr_en && file_wr_data == ~$past(fval))
    else $error("complement result wrong");

  decrement_a: assert property (exec && op == mcc_pkg::OP_DECREMENT && dest |=>
    file_wr_en && file_wr_data == $past(fval) - 8'h01)
    else $error("decrement result wrong");

  dec_skip_a: assert property (exec && op == mcc_pkg::OP_DEC_SKIP && fval == 8'h01 |=>
    $stable(z) and skip_slot_s)
    else $error("decrement skip did not discard next instruction");

  increment_a: assert property (exec && op == mcc_pkg::OP_INCREMENT && fval == 8'hff |=>
    z && ($past(dest) ? file_wr_data == 8'h00 : w == 8'h00))
    else $error("increment did not wrap to zero");

  inc_skip_a: assert property (exec && op == mcc_pkg::OP_INC_SKIP && fval != 8'hff |=>
    $stable(z) && state == mcc_pkg::ST_EXEC && pc == $past(pc) + 13'h0001)
    else $error("increment skip took a skip on nonzero result");

  or_literal_a: assert property (exec && op == mcc_pkg::OP_OR_LITERAL |=>
    w == ($past(w) | $past(lit)))
    else $error("or literal result wrong");

  or_file_a: assert property (exec && op == mcc_pkg::OP_OR_FILE && dest |=>
    file_wr_en && file_wr_data == ($past(w) | $past(fval)))
    else $error("or file result wrong");

  call_seq_a: assert property (exec && op == mcc_pkg::OP_CALL |=>
    pc == $past(target) && stack_push_data == $past(pc_inc) ##0 call_tail_s)
    else $error("call did not push return address and take two cycles");

  zero_flag_a: assert property (exec && upd_z |=> z == ($past(alu_result) == 8'h00))
    else $error("zero flag does not match result");

  // Skip slot, routing and step checks
  dec_noskip_a: assert property (exec && op == mcc_pkg::OP_DEC_SKIP && fval != 8'h01 |=>
    $stable(z) && state == mcc_pkg::ST_EXEC)
    else $error("decrement skip took a skip on nonzero result");

  inc_zero_a: assert property (exec && op == mcc_pkg::OP_INC_SKIP && fval == 8'hff |=>
    $stable(z) and skip_slot_s)
    else $error("increment skip did not discard next instruction");

  skip_nop_a: assert property (state == mcc_pkg::ST_SKIP |=>
    !file_wr_en && !stack_push && !wdt_clear && $stable(z))
    else $error("discarded instruction had an effect");

  skip_pc_a: assert property (exec && skip |=>
    pc == $past(pc) + 13'h0001 && state == mcc_pkg::ST_SKIP)
    else $error("skip did not step to the discarded slot");

  dest_file_a: assert property (exec && routed_op && dest |=>
    file_wr_en && file_wr_addr == $past(faddr) && file_wr_data == $past(alu_result))
    else $error("destination one did not write the file register");

  complement_w_a: assert property (exec && op == mcc_pkg::OP_COMPLEMENT && !dest |=>
    w == ~$past(fval) && !file_wr_en)
    else $error("complement to working register wrong");

  inc_to_w_a: assert property (exec && op == mcc_pkg::OP_INC_SKIP && !dest |=>
    w == $past(fval) + 8'h01 && !file_wr_en)
    else $error("increment skip to working register wrong");
endmodule

// ===== sim/mcc_mem_model.sv
// Program memory and data file model facing the execute unit
`timescale 1ns/1ns
module mcc_mem_model (
  input wire logic clk_sys,
  input wire logic [12:0] instr_addr,
  output logic [15:0] instr_data,
  input wire logic [8:0] file_addr,
  output logic [7:0] file_rd_data,
  input wire logic file_wr_en,
  input wire logic [8:0] file_wr_addr,
  input wire logic [7:0] file_wr_data
);
  logic [15:0] prog [0:8191];
  logic [7:0] ram [0:511];
  initial begin
    foreach (prog[i]) prog[i] = 16'h0000;
    foreach (ram[i]) ram[i] = 8'h00;
  end
  // Opcode and file byte answer within the same cycle
  assign instr_data = prog[instr_addr];
  assign file_rd_data = ram[file_addr];
  always @(posedge clk_sys) begin
    if (file_wr_en === 1'b1) begin
      ram[file_wr_addr] <= file_wr_data;
    end
  end
endmodule

// ===== sim/tb.sv
// Self-checking bench for the instruction execute unit
`timescale 1ns/1ns
module tb;
  logic clk_sys, rst, psel, penable, pwrite, pready, pslverr, err;
  logic file_wr_en, stack_push, wdt_clear;
  logic [7:0] paddr, file_rd_data, file_wr_data;
  logic [31:0] pwdata, prdata, rd;
  logic [12:0] instr_addr, stack_push_data, push_val;
  logic [15:0] instr_data;
  logic [8:0] file_addr, file_wr_addr;
  logic [12:0] trace[$];
  int n_errors = 0;
  int check_count = 0;
  int cyc = 0;
  int n_wdt = 0;
  int n_push = 0;

  mcc_core_exec u_dut (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .instr_addr(instr_addr), .instr_data(instr_data),
    .file_addr(file_addr), .file_rd_data(file_rd_data), .file_wr_en(file_wr_en),
    .file_wr_addr(file_wr_addr), .file_wr_data(file_wr_data), .stack_push(stack_push),
    .stack_push_data(stack_push_data), .wdt_clear(wdt_clear));
  mcc_mem_model u_mem (.clk_sys(clk_sys), .instr_addr(instr_addr), .instr_data(instr_data),
    .file_addr(file_addr), .file_rd_data(file_rd_data), .file_wr_en(file_wr_en),
    .file_wr_addr(file_wr_addr), .file_wr_data(file_wr_data));

  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  task automatic give_verdict();
    if (n_errors == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Pulse counters and hang guard
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (wdt_clear === 1'b1) n_wdt <= n_wdt + 1;
    if (stack_push === 1'b1) begin
      n_push <= n_push + 1;
      push_val <= stack_push_data;
    end
    if (cyc == 20000) begin
      n_errors++;
      give_verdict();
    end
  end
  always @(negedge clk_sys) trace.push_back(instr_addr);

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic logic [15:0] fop(logic [3:0] sub, logic d, logic [8:0] a);
    return {a[8:7], 2'b00, sub, d, a[6:0]};
  endfunction

  // Last cycle that still shows the start address before execution moves on
  function automatic int start_of(logic [12:0] b);
    for (int i = 0; i < trace.size() - 1; i++) begin
      if (trace[i] === b && trace[i + 1] !== b) return i;
    end
    return 0;
  endfunction

  task automatic run_prog(input logic [12:0] b, input int n);
    apb(1'b1, mcc_pkg::PC_OFS, {19'h0, b});
    trace.delete();
    apb(1'b1, mcc_pkg::CTRL_OFS, 32'h1);
    repeat (n) @(posedge clk_sys);
    apb(1'b1, mcc_pkg::CTRL_OFS, 32'h0);
  endtask

  task automatic test_regs();
    apb(1'b0, mcc_pkg::CTRL_OFS, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, mcc_pkg::STAT_OFS, 32'h0);
    chk(rd, 32'h6);
    apb(1'b1, mcc_pkg::STAT_OFS, 32'h0);
    apb(1'b0, mcc_pkg::STAT_OFS, 32'h0);
    chk(rd, 32'h6);
    apb(1'b0, 8'h10, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
  endtask

  task automatic test_ops();
    logic [12:0] b;
    int s;
    int w0;
    b = 13'h0010;
    w0 = n_wdt;
    u_mem.ram[9'h185] = 8'h13;
    u_mem.ram[9'h005] = 8'h01;
    u_mem.ram[9'h100] = 8'hff;
    u_mem.ram[9'h1ff] = 8'h02;
    u_mem.ram[9'h07f] = 8'h5a;
    u_mem.prog[b] = fop(mcc_pkg::SUB_COMPLEMENT, 1'b0, 9'h185);
    u_mem.prog[b + 1] = fop(mcc_pkg::SUB_OR_FILE, 1'b1, 9'h185);
    u_mem.prog[b + 2] = fop(mcc_pkg::SUB_DECREMENT, 1'b1, 9'h005);
    u_mem.prog[b + 3] = fop(mcc_pkg::SUB_INCREMENT, 1'b1, 9'h100);
    u_mem.prog[b + 4] = fop(mcc_pkg::SUB_DEC_SKIP, 1'b1, 9'h1ff);
    u_mem.prog[b + 5] = fop(mcc_pkg::SUB_DEC_SKIP, 1'b1, 9'h1ff);
    u_mem.prog[b + 6] = fop(mcc_pkg::SUB_INCREMENT, 1'b1, 9'h0ff);
    u_mem.prog[b + 7] = fop(mcc_pkg::SUB_INC_SKIP, 1'b0, 9'h07f);
    u_mem.prog[b + 8] = {mcc_pkg::LIT_OR_ACCUM, 8'h24};
    u_mem.prog[b + 9] = fop(mcc_pkg::SUB_CLEAR_FILE, 1'b1, 9'h07f);
    u_mem.prog[b + 10] = mcc_pkg::OPC_WATCHDOG_CLR;
    apb(1'b1, mcc_pkg::WREG_OFS, 32'h91);
    run_prog(b, 30);
    s = start_of(b);
    chk(u_mem.ram[9'h185], 8'hff);
    chk(u_mem.ram[9'h005], 8'h00);
    chk(u_mem.ram[9'h100], 8'h00);
    chk(u_mem.ram[9'h1ff], 8'h00);
    chk(u_mem.ram[9'h07f], 8'h00);
    chk(u_mem.ram[9'h0ff], 8'h00);
    apb(1'b0, mcc_pkg::WREG_OFS, 32'h0);
    chk(rd, 32'h7f);
    apb(1'b0, mcc_pkg::STAT_OFS, 32'h0);
    chk(rd, 32'h7);
    chk(n_wdt - w0, 1);
    chk(trace[s + 11], b + 11);
  endtask

  task automatic test_call_skip();
    logic [12:0] b;
    int s;
    int p0;
    b = 13'h0200;
    p0 = n_push;
    u_mem.ram[9'h0ff] = 8'hff;
    u_mem.prog[b] = mcc_pkg::OPC_CLEAR_ACCUM;
    u_mem.prog[b + 1] = fop(mcc_pkg::SUB_INC_SKIP, 1'b1, 9'h0ff);
    u_mem.prog[b + 2] = {mcc_pkg::LIT_OR_ACCUM, 8'h80};
    u_mem.prog[b + 3] = {2'b10, mcc_pkg::CALL_GROUP, 11'h155};
    apb(1'b1, mcc_pkg::WREG_OFS, 32'h33);
    run_prog(b, 20);
    s = start_of(b);
    chk(u_mem.ram[9'h0ff], 8'h00);
    apb(1'b0, mcc_pkg::WREG_OFS, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, mcc_pkg::STAT_OFS, 32'h0);
    chk(rd[0], 1'b1);
    chk(n_push - p0, 1);
    chk(push_val, b + 4);
    chk(trace[s + 4], 13'h1155);
    chk(trace[s + 5], 13'h1155);
    chk(trace[s + 6], 13'h1156);
  endtask

  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    test_regs();
    test_ops();
    test_call_skip();
    give_verdict();
  end
endmodule
